// ==== hw/dcwb_top.sv ====
// write buffer, dependency check and flush control of the data cache
`timescale 1ns/1ps
//Contract
//[RL1] two entries: address, data, width, valid
//[RL2] store fills head if free, else tail
//[RL3] memory writes come only from head
//[RL4] request when interface idle, lowest priority
//[RL5] release head at dram last, rom after
//[RL6] freed head reloads same cycle
//[RL7] tail refills same cycle it shifts
//[RL8] full buffer stalls store until tail frees
//[RL9] stalled store raises head to data priority
//[RL10] shift tail, write store, then advance
//[RL11] dram release lets pipeline go at precharge
//[RL12] compare bits 9-4 against active entries
//[RL13] no match: reload proceeds, buffer holds
//[RL14] match: drain needed stores, head first
//[RL15] uncached single load also dependency held
//[RL16] serialization drains whole buffer first
//[RL17] no snooping of external master writes
//[RL18] reset or flush clears valids at once
//[RL19] flush only in supervisor mode
//[RL20] buffer untouched; locked kept unless disabled
//[RL21] locked loads bypass, invalidate hit block
//[RL22] noncacheable waits empty; bypass when disabled
//[RL23] width drives byte enables of write
module dcwb_top #(
	parameter int AW = 32,
	parameter int DW = 32
) (
	// clock and reset
	input  wire logic          CLK,
	input  wire logic          RST,
	// pipeline store
	input  wire logic          ST_REQ,
	input  wire logic          ST_CACHEABLE,
	input  wire logic [AW-1:0] ST_ADDR,
	input  wire logic [DW-1:0] ST_DATA,
	input  wire logic [1:0]    ST_WIDTH,
	// pipeline load
	input  wire logic          LD_MISS,
	input  wire logic          LD_SINGLE,
	input  wire logic          LD_NONCACHE,
	input  wire logic          LD_LOCKED,
	input  wire logic          LD_HIT,
	input  wire logic          LD_HIT_COL,
	input  wire logic [AW-1:0] LD_ADDR,
	// control
	input  wire logic          SERIALIZE,
	input  wire logic          FLUSH_INSTR,
	input  wire logic          SUPERVISOR,
	input  wire logic          CACHE_DISABLE,
	input  wire logic [1:0]    CACHE_LOCK,
	input  wire logic          FILL_EN,
	input  wire logic          FILL_COL,
	// memory interface
	input  wire logic          MEM_IDLE,
	input  wire logic          MEM_GRANT,
	input  wire logic          MEM_IS_DRAM,
	input  wire logic          MEM_LAST,
	output logic               MEM_REQ,
	output logic [1:0]         MEM_PRIO,
	output logic [AW-1:0]      MEM_ADDR,
	output logic [DW-1:0]      MEM_DATA,
	output logic [3:0]         MEM_BE,
	// pipeline answers
	output logic               STALL,
	output logic               LD_GO,
	output logic               BUF_EMPTY,
	output logic [1:0]         VALID_AT_LD
);
	localparam int IW = dcwb_pkg::IDX_W;

	// entry storage
	logic [AW-1:0] addr [2];
	logic [DW-1:0] data [2];
	logic [1:0]    wid  [2];
	logic [1:0]    vld;
	logic [AW-1:0] next_addr [2];
	logic [DW-1:0] next_data [2];
	logic [1:0]    next_wid  [2];
	logic [1:0]    next_vld;
	dcwb_pkg::dcwb_state_t state;
	dcwb_pkg::dcwb_state_t next_state;
	logic          rom_tail;
	logic          next_rom_tail;
	logic          release_h;
	logic          take;
	logic          drain;
	logic [1:0]    match;
	logic          dep;
	logic          cache_st;
	logic          next_stall;
	logic          next_ld_go;
	logic [1:0]    next_prio;
	logic [3:0]    next_be;
	logic          do_flush;

	// bits 9-4 compare per entry
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_cmp
			assign match[g] = vld[g] &&
				(addr[g][dcwb_pkg::IDX_HI:dcwb_pkg::IDX_LO] ==
				LD_ADDR[dcwb_pkg::IDX_HI:dcwb_pkg::IDX_LO]); // [RL12]
		end
	endgenerate

	// [RL15]
	assign dep = (LD_MISS || LD_SINGLE) && (match != 2'h0);
	// [RL22]
	assign cache_st = ST_REQ && ST_CACHEABLE && !CACHE_DISABLE;
	// [RL19]
	assign do_flush = FLUSH_INSTR && SUPERVISOR;
	// [RL14] [RL16] [RL22]
	assign drain = dep || SERIALIZE || LD_NONCACHE ||
		(ST_REQ && !cache_st);

	always_comb begin
		next_state = state;
		next_rom_tail = 1'b0;
		release_h = 1'b0;
		case (state)
			dcwb_pkg::DCWB_IDLE: begin
				if (vld[0] && MEM_GRANT) // [RL3]
					next_state = dcwb_pkg::DCWB_BUSY;
			end
			dcwb_pkg::DCWB_BUSY: begin
				if (rom_tail) begin
					release_h = 1'b1; // [RL5]
					next_state = dcwb_pkg::DCWB_IDLE;
				end else if (MEM_LAST && MEM_IS_DRAM) begin
					release_h = 1'b1; // [RL5] [RL11]
					next_state = dcwb_pkg::DCWB_IDLE;
				end else if (MEM_LAST) begin
					next_rom_tail = 1'b1;
				end
			end
			default: next_state = dcwb_pkg::DCWB_IDLE;
		endcase
	end

	always_comb begin
		next_addr = addr;
		next_data = data;
		next_wid  = wid;
		next_vld  = vld;
		take = 1'b0;
		if (release_h) begin
			next_addr[0] = addr[1]; // [RL6] [RL10]
			next_data[0] = data[1];
			next_wid[0]  = wid[1];
			next_vld[0]  = vld[1];
			next_vld[1]  = 1'b0;
		end
		if (cache_st) begin
			if (!next_vld[0]) begin
				next_addr[0] = ST_ADDR; // [RL2]
				next_data[0] = ST_DATA;
				next_wid[0]  = ST_WIDTH;
				next_vld[0]  = 1'b1;
				take = 1'b1;
			end else if (!next_vld[1]) begin
				next_addr[1] = ST_ADDR; // [RL2] [RL7] [RL10]
				next_data[1] = ST_DATA;
				next_wid[1]  = ST_WIDTH;
				next_vld[1]  = 1'b1;
				take = 1'b1;
			end
		end
		// [RL1] [RL20] flush leaves entries alone
	end

	always_comb begin
		next_stall = cache_st && !take; // [RL8]
		if (drain && next_vld != 2'h0)
			next_stall = 1'b1; // [RL16] [RL22]
		// [RL13] reload passes buffer when no match
		next_ld_go = (LD_MISS || LD_SINGLE || LD_NONCACHE || LD_LOCKED) &&
			!dep && !(LD_NONCACHE && vld != 2'h0);
		next_prio = (cache_st && !take) || drain ?
			dcwb_pkg::PRIO_DATA : dcwb_pkg::PRIO_LOW; // [RL4] [RL9]
		case (next_wid[0]) // [RL23]
			dcwb_pkg::WIDTH_BYTE: next_be = 4'h1 << next_addr[0][1:0];
			dcwb_pkg::WIDTH_HALF:
				next_be = next_addr[0][1] ? 4'hc : 4'h3;
			default:              next_be = 4'hf;
		endcase
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state <= dcwb_pkg::DCWB_IDLE;
			rom_tail <= 1'b0;
			vld <= 2'h0;
			for (int i = 0; i < 2; i++) begin
				addr[i] <= '0;
				data[i] <= '0;
				wid[i]  <= dcwb_pkg::WIDTH_WORD;
			end
			MEM_REQ <= 1'b0;
			MEM_PRIO <= dcwb_pkg::PRIO_LOW;
			MEM_ADDR <= '0;
			MEM_DATA <= '0;
			MEM_BE <= 4'h0;
			STALL <= 1'b0;
			LD_GO <= 1'b0;
			BUF_EMPTY <= 1'b1;
		end else begin
			state <= next_state;
			rom_tail <= next_rom_tail;
			vld <= next_vld;
			addr <= next_addr;
			data <= next_data;
			wid <= next_wid;
			// [RL3] [RL4] request while head valid and bus idle, or at data priority
			MEM_REQ <= next_vld[0] && next_state == dcwb_pkg::DCWB_IDLE &&
				(MEM_IDLE || next_prio == dcwb_pkg::PRIO_DATA);
			MEM_PRIO <= next_prio;
			MEM_ADDR <= next_addr[0];
			MEM_DATA <= next_data[0];
			MEM_BE <= next_be;
			STALL <= next_stall;
			LD_GO <= next_ld_go;
			BUF_EMPTY <= next_vld == 2'h0;
		end
	end

	// valid bits; no port for external writes [RL17]
	dcwb_valid_array #(
		.SETS(dcwb_pkg::NUM_SETS),
		.IW(IW)
	) u_valid (
		.clk(CLK),
		.rst(RST), // [RL18]
		.flush(do_flush), // [RL18]
		.keep_locked(!CACHE_DISABLE), // [RL20]
		.inv_en(LD_LOCKED && LD_HIT), // [RL21]
		.inv_idx(LD_ADDR[dcwb_pkg::IDX_HI:dcwb_pkg::IDX_LO]),
		.inv_col(LD_HIT_COL),
		.set_en(FILL_EN),
		.set_idx(LD_ADDR[dcwb_pkg::IDX_HI:dcwb_pkg::IDX_LO]),
		.set_col(FILL_COL),
		.lock(CACHE_LOCK),
		.rd_idx(LD_ADDR[dcwb_pkg::IDX_HI:dcwb_pkg::IDX_LO]),
		.rd_valid(VALID_AT_LD)
	);
endmodule

// ==== hw/dcwb_pkg.sv ====
// package: constants and types for the data cache write buffer
package dcwb_pkg;
	localparam int ADDR_W       = 32;
	localparam int DATA_W       = 32;
	localparam int IDX_HI       = 9;
	localparam int IDX_LO       = 4;
	localparam int IDX_W        = IDX_HI - IDX_LO + 1;
	localparam int NUM_SETS     = 64;
	localparam logic [1:0] WIDTH_BYTE = 2'h0;
	localparam logic [1:0] WIDTH_HALF = 2'h1;
	localparam logic [1:0] WIDTH_WORD = 2'h2;
	localparam logic [1:0] PRIO_LOW   = 2'h0;
	localparam logic [1:0] PRIO_DATA  = 2'h2;
	typedef enum logic [1:0] {
		DCWB_IDLE = 2'b00,
		DCWB_BUSY = 2'b01
	} dcwb_state_t;
endpackage

// ==== hw/dcwb_valid_array.sv ====
// valid and lock bits of the data cache blocks
`timescale 1ns/1ps
module dcwb_valid_array #(
	parameter int SETS = 64,
	parameter int IW   = 6
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rst,
	// flush
	input  wire logic          flush,
	input  wire logic          keep_locked,
	// single block clear
	input  wire logic          inv_en,
	input  wire logic [IW-1:0] inv_idx,
	input  wire logic          inv_col,
	// fill
	input  wire logic          set_en,
	input  wire logic [IW-1:0] set_idx,
	input  wire logic          set_col,
	// lock bits per column
	input  wire logic [1:0]    lock,
	// lookup
	input  wire logic [IW-1:0] rd_idx,
	output logic [1:0]         rd_valid
);
	logic [SETS-1:0] vld [2];
	logic [SETS-1:0] next_vld [2];

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			next_vld[c] = vld[c];
			if (flush) begin
				next_vld[c] = (keep_locked && lock[c]) ? vld[c] : '0;
			end else begin
				if (inv_en && inv_col == c[0])
					next_vld[c][inv_idx] = 1'b0;
				if (set_en && set_col == c[0])
					next_vld[c][set_idx] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			vld[0] <= '0;
			vld[1] <= '0;
			rd_valid <= 2'h0;
		end else begin
			vld[0] <= next_vld[0];
			vld[1] <= next_vld[1];
			rd_valid <= {next_vld[1][rd_idx], next_vld[0][rd_idx]};
		end
	end
endmodule

// ==== testbench/dcwb_top_sva.sv ====
// assertions on the write buffer ports
`timescale 1ns/1ps
module dcwb_top_chk (
	input wire logic       CLK,
	input wire logic       RST,
	input wire logic       SERIALIZE,
	input wire logic       LD_MISS,
	input wire logic       MEM_IDLE,
	input wire logic       MEM_REQ,
	input wire logic [1:0] MEM_PRIO,
	input wire logic [3:0] MEM_BE,
	input wire logic       STALL,
	input wire logic       LD_GO,
	input wire logic       BUF_EMPTY
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	sequence s_busy;
		(!BUF_EMPTY && MEM_IDLE) [*2];
	endsequence
	sequence s_drained;
		##[1:60] BUF_EMPTY;
	endsequence
	property p_idle;
		$fell(RST) |-> BUF_EMPTY && !STALL && !MEM_REQ;
	endproperty
	property p_be;
		MEM_REQ |-> MEM_BE != 4'h0;
	endproperty
	property p_prio;
		STALL && MEM_REQ |-> MEM_PRIO == dcwb_pkg::PRIO_DATA;
	endproperty
	property p_stall;
		STALL |-> ##[1:40] !STALL;
	endproperty
	property p_full;
		BUF_EMPTY |-> !STALL;
	endproperty
	property p_drain;
		SERIALIZE && !BUF_EMPTY |-> s_drained;
	endproperty
	property p_req;
		s_busy |-> ##[0:1] MEM_REQ;
	endproperty
	property p_go;
		$rose(LD_MISS) && BUF_EMPTY |=> LD_GO;
	endproperty
	a_idle: assert property (p_idle) else $error("bad reset state");
	a_be: assert property (p_be) else $error("no byte enable");
	a_prio: assert property (p_prio) else $error("prio not raised");
	a_stall: assert property (p_stall) else $error("stall hangs");
	a_full: assert property (p_full) else $error("stall on empty");
	a_drain: assert property (p_drain) else $error("no drain");
	a_req: assert property (p_req) else $error("idle not used");
	a_go: assert property (p_go) else $error("load held");
endmodule
bind dcwb_top dcwb_top_chk u_chk (.*);

// ==== testbench/dcwb_mem_model.sv ====
// memory interface model taking head writes
`timescale 1ns/1ps
module dcwb_mem_model (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic req,
	input  wire logic hold,
	output logic      idle,
	output logic      grant,
	output logic      last
);
	int cnt;
	assign idle = !hold && cnt == 0;
	assign grant = cnt == 4;
	assign last = cnt == 1;
	always @(posedge clk or posedge rst) begin
		if (rst)
			cnt <= 0;
		else if (cnt > 0)
			cnt <= cnt - 1;
		else if (idle && req)
			cnt <= 4;
	end
endmodule

// ==== testbench/tb_dcwb_top.sv ====
// testbench of the write buffer
`timescale 1ns/1ps
module tb_dcwb_top;
	typedef struct {logic [1:0] w; logic [31:0] a, d; int n;} dcwb_row_t;
	logic        CLK = 0, RST = 1, ST_REQ = 0, ST_CACHEABLE = 1;
	logic [31:0] ST_ADDR = 0, ST_DATA = 0, LD_ADDR = 0, MEM_ADDR, MEM_DATA;
	logic [1:0]  ST_WIDTH = 0, CACHE_LOCK = 0, MEM_PRIO, VALID_AT_LD;
	logic        LD_MISS = 0, LD_SINGLE = 0, LD_NONCACHE = 0, LD_LOCKED = 0;
	logic        LD_HIT = 0, LD_HIT_COL = 0, SERIALIZE = 0, FLUSH_INSTR = 0;
	logic        SUPERVISOR = 0, CACHE_DISABLE = 0, FILL_EN = 0, FILL_COL = 0;
	logic        MEM_IDLE, MEM_GRANT, MEM_IS_DRAM = 1, MEM_LAST, MEM_REQ;
	logic        STALL, LD_GO, BUF_EMPTY, hold = 0;
	logic [3:0]  MEM_BE;
	logic [31:0] q[$];
	int          fail_count = 0, n_tests = 0;
	dcwb_row_t   rows[3] = '{'{dcwb_pkg::WIDTH_BYTE, 32'h10, 32'h11111111, 1},
		'{dcwb_pkg::WIDTH_HALF, 32'h20, 32'h22222222, 2},
		'{dcwb_pkg::WIDTH_WORD, 32'h30, 32'h12345678, 4}};
	dcwb_top u_dcwb_top (.*);
	dcwb_mem_model u_dcwb_mem_model (.clk(CLK), .rst(RST), .req(MEM_REQ),
		.hold(hold), .idle(MEM_IDLE), .grant(MEM_GRANT), .last(MEM_LAST));
	initial forever #5 CLK = ~CLK;
	always @(posedge CLK) if (MEM_GRANT) q.push_back(MEM_ADDR);
	task automatic give_verdict();
		$display("checks %0d errors %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick(int n = 1);
		repeat (n) @(posedge CLK);
		#1;
	endtask
	function automatic logic sig(int w);
		return w == 0 ? MEM_GRANT : w == 1 ? BUF_EMPTY : w == 2 ? LD_GO : !STALL;
	endfunction
	task automatic wt(int w);
		int i;
		for (i = 0; i < 99 && sig(w) !== 1'b1; i++)
			tick();
		if (i == 99) begin
			fail_count++;
			give_verdict();
		end
	endtask
	task automatic store(logic [1:0] w, logic [31:0] a, d);
		ST_WIDTH = w;
		ST_ADDR = a;
		ST_DATA = d;
		ST_REQ = 1;
		tick();
		wt(3);
	endtask
	initial begin
		tick(12);
		chk({BUF_EMPTY, STALL, MEM_REQ, VALID_AT_LD}, 5'h10);
		RST = 0;
		foreach (rows[i]) begin
			MEM_IS_DRAM = i > 0;
			store(rows[i].w, rows[i].a, rows[i].d);
			ST_REQ = 0;
			wt(0);
			chk(MEM_ADDR, rows[i].a);
			chk(MEM_DATA, rows[i].d);
			chk(32'($countones(MEM_BE)), rows[i].n);
			wt(1);
		end
		hold = 1;
		q.delete();
		store(dcwb_pkg::WIDTH_WORD, 32'h100, 1);
		store(dcwb_pkg::WIDTH_WORD, 32'h200, 2);
		ST_ADDR = 32'h300;
		tick(2);
		chk(STALL, 1);
		chk(MEM_PRIO, dcwb_pkg::PRIO_DATA);
		hold = 0;
		wt(3);
		ST_REQ = 0;
		wt(1);
		for (int k = 0; k < 3; k++)
			chk(q[k], (k + 1) << 8);
		for (int k = 0; k < 3; k++) begin
			hold = 1;
			store(dcwb_pkg::WIDTH_WORD, 32'h230, k);
			ST_REQ = 0;
			LD_ADDR = 32'h5630;
			{LD_NONCACHE, LD_SINGLE, LD_MISS} = 3'(1 << k);
			tick(4);
			chk(LD_GO, 0);
			hold = 0;
			wt(2);
			chk(BUF_EMPTY, 1);
			{LD_NONCACHE, LD_SINGLE, LD_MISS} = 3'h0;
		end
		hold = 1;
		store(dcwb_pkg::WIDTH_WORD, 32'h240, 7);
		ST_REQ = 0;
		LD_ADDR = 32'h250;
		LD_MISS = 1;
		wt(2);
		LD_MISS = 0;
		chk(BUF_EMPTY, 0);
		SERIALIZE = 1;
		hold = 0;
		wt(1);
		SERIALIZE = 0;
		LD_ADDR = 32'h70;
		LD_MISS = 1;
		wt(2);
		LD_MISS = 0;
		FILL_EN = 1;
		tick();
		FILL_EN = 0;
		for (int k = 0; k < 2; k++) begin
			SUPERVISOR = 1'(k);
			FLUSH_INSTR = 1;
			tick();
			FLUSH_INSTR = 0;
			tick(2);
			chk(VALID_AT_LD, k ? 0 : 1);
		end
		FILL_EN = 1;
		CACHE_LOCK = 2'h1;
		tick();
		FILL_EN = 0;
		FLUSH_INSTR = 1;
		tick();
		FLUSH_INSTR = 0;
		tick(2);
		chk(VALID_AT_LD, 1);
		CACHE_DISABLE = 1;
		FLUSH_INSTR = 1;
		tick();
		FLUSH_INSTR = 0;
		tick(2);
		chk(VALID_AT_LD, 0);
		CACHE_DISABLE = 0;
		FILL_EN = 1;
		tick();
		FILL_EN = 0;
		tick();
		chk(VALID_AT_LD, 1);
		LD_LOCKED = 1;
		LD_HIT = 1;
		tick();
		LD_LOCKED = 0;
		LD_HIT = 0;
		tick(2);
		chk(VALID_AT_LD, 0);
		give_verdict();
	end
endmodule
